// File: design/icv_defs.svh
`ifndef ICV_DEFS_SVH
`define ICV_DEFS_SVH
`define ICV_OFS_DIGITAL_SETUP   8'h04
`define ICV_OFS_ALT_SETUP       8'h05
`define ICV_OFS_LIMIT_LOW       8'h06
`define ICV_OFS_LIMIT_HIGH      8'h07
`define ICV_OFS_SHUTDOWN        8'h0b
`define ICV_OFS_RESULT          8'h20
`define ICV_OFS_STATUS          8'h24
`define ICV_OFS_MASK            8'h28
`define ICV_RST_DIGITAL_SETUP   8'h03
`define ICV_RST_ALT_SETUP       8'h00
`define ICV_RST_LIMIT           8'h00
`define ICV_BIT_SHUTDOWN_GATE   1
`define ICV_BIT_INDUCT_ONLY     0
`define ICV_BIT_READY_POLICY    2
`define ICV_BIT_SHUTDOWN_REQ    1
`define ICV_ST_LOSS_ABOVE       0
`define ICV_ST_CONV_DONE        1
`define ICV_DIVISOR             16'h0003
`define ICV_PER_192             16'd192
`define ICV_PER_384             16'd384
`define ICV_PER_768             16'd768
`define ICV_PER_1536            16'd1536
`define ICV_PER_3072            16'd3072
`define ICV_PER_6144            16'd6144
`endif

// File: design/icv_pkg.sv
package icv_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic       write;
    logic [7:0] wdata;
  } icv_req_t;
  typedef struct packed {
    logic        valid;
    logic        is_loss;
    logic [15:0] value;
  } icv_result_t;
  typedef enum logic [1:0] {ICV_IDLE, ICV_RUN, ICV_DONE} icv_state_t;
endpackage

// File: design/icv_period_map.sv
`timescale 1ns/100ps
`include "icv_defs.svh"
module icv_period_map
  import icv_pkg::*;
(
  input  wire logic [2:0]  code_i,
  output logic      [15:0] periods_o
);
  always_comb
  begin
    case (code_i)
      3'h2:    periods_o = `ICV_PER_192;
      3'h3:    periods_o = `ICV_PER_384;
      3'h4:    periods_o = `ICV_PER_768;
      3'h5:    periods_o = `ICV_PER_1536;
      3'h6:    periods_o = `ICV_PER_3072;
      3'h7:    periods_o = `ICV_PER_6144;
      // Reserved codes fall back to the reset length rather than stalling
      default: periods_o = `ICV_PER_384;
    endcase
  end
endmodule

// File: design/icv_sync2.sv
`timescale 1ns/100ps
module icv_sync2
  import icv_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_r;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= 1'b0;
      q_o    <= 1'b0;
    end
    else
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule

// File: design/icv_top.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`include "icv_defs.svh"
module icv_top
  import icv_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        sensor_tick_i,
  input  wire logic [15:0] loss_sample_i,
  input  wire logic [15:0] induct_sample_i,
  output logic             irq_o,
  output logic             shutdown_o,
  output logic             loss_active_o,
  output logic             conv_busy_o,
  output logic [15:0]      loss_upper_limit_o
);
  logic [7:0]  digital_setup_r;
  logic [7:0]  alternate_setup_r;
  logic [7:0]  limit_low_stage_r;
  logic [7:0]  limit_high_r;
  logic [15:0] loss_upper_limit_r;
  logic        shutdown_req_r;
  logic [1:0]  status_r;
  logic [1:0]  mask_r;
  logic [15:0] last_result_r;
  logic        last_is_loss_r;
  icv_state_t  state_r;
  logic [15:0] tick_cnt_r;
  logic [15:0] conv_cnt_r;
  logic [15:0] periods;
  logic [15:0] conv_ticks;
  logic        tick_sync;
  logic        tick_prev_r;
  logic        tick_edge;
  logic        access;
  logic        wr_en;
  logic [7:0]  addr;
  logic        mapped;
  logic        conv_done;
  logic        loss_done;
  logic [1:0]  events;
  logic        inductance_only_drive;
  icv_result_t result;

  assign access = psel_i && penable_i;
  // One write per transfer: the held second access cycle must not clear status again
  assign wr_en  = access && !pready_o && pwrite_i && mapped;
  // Register offsets are word indices; byte address is four times the index
  assign addr   = paddr_i[9:2];
  assign inductance_only_drive = alternate_setup_r[`ICV_BIT_INDUCT_ONLY];

  icv_sync2 u_tick_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .d_i       (sensor_tick_i),
    .q_o       (tick_sync)
  );

  icv_period_map u_period_map (
    .code_i    (digital_setup_r[2:0]),
    .periods_o (periods)
  );

  // Divide by three once; integer truncation loses at most one tick
  assign conv_ticks = periods / `ICV_DIVISOR;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      tick_prev_r <= 1'b0;
    else
      tick_prev_r <= tick_sync;
  end
  assign tick_edge = tick_sync && !tick_prev_r;

  always_comb
  begin
    if (paddr_i[1:0] != 2'h0 || paddr_i[31:10] != 22'h00_0000)
      mapped = 1'b0;
    else if (addr == `ICV_OFS_DIGITAL_SETUP || addr == `ICV_OFS_ALT_SETUP)
      mapped = 1'b1;
    else if (addr == `ICV_OFS_LIMIT_LOW || addr == `ICV_OFS_LIMIT_HIGH)
      mapped = 1'b1;
    else if (addr == `ICV_OFS_SHUTDOWN || addr == `ICV_OFS_RESULT)
      mapped = 1'b1;
    else if (addr == `ICV_OFS_STATUS || addr == `ICV_OFS_MASK)
      mapped = 1'b1;
    else
      mapped = 1'b0;
  end

  // Configuration registers; writable in any state, including mid-conversion
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      digital_setup_r   <= `ICV_RST_DIGITAL_SETUP;
      alternate_setup_r <= `ICV_RST_ALT_SETUP;
      shutdown_req_r    <= 1'b0;
      mask_r            <= 2'h0;
    end
    else if (wr_en)
    begin
      if (addr == `ICV_OFS_DIGITAL_SETUP)
        digital_setup_r <= pwdata_i[7:0];
      else if (addr == `ICV_OFS_ALT_SETUP)
        alternate_setup_r <= pwdata_i[7:0];
      else if (addr == `ICV_OFS_SHUTDOWN)
        shutdown_req_r <= pwdata_i[`ICV_BIT_SHUTDOWN_REQ];
      else if (addr == `ICV_OFS_MASK)
        mask_r <= pwdata_i[1:0];
    end
  end

  // Low byte staged; active limit changes only with a high byte write
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      limit_low_stage_r  <= `ICV_RST_LIMIT;
      limit_high_r       <= `ICV_RST_LIMIT;
      loss_upper_limit_r <= {`ICV_RST_LIMIT, `ICV_RST_LIMIT};
    end
    else if (wr_en)
    begin
      if (addr == `ICV_OFS_LIMIT_LOW)
        limit_low_stage_r <= pwdata_i[7:0];
      else if (addr == `ICV_OFS_LIMIT_HIGH)
      begin
        limit_high_r       <= pwdata_i[7:0];
        loss_upper_limit_r <= {pwdata_i[7:0], limit_low_stage_r};
      end
    end
  end

  // Conversion sequencer counts sensor ticks; shutdown holds it idle
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state_r    <= ICV_IDLE;
      tick_cnt_r <= 16'h0000;
    end
    else
    begin
      case (state_r)
        ICV_IDLE:
        begin
          tick_cnt_r <= 16'h0000;
          if (!shutdown_o)
            state_r <= ICV_RUN;
        end
        ICV_RUN:
        begin
          if (shutdown_o)
            state_r <= ICV_IDLE;
          else if (tick_edge)
          begin
            if (tick_cnt_r + 16'h0001 >= conv_ticks)
              state_r <= ICV_DONE;
            tick_cnt_r <= tick_cnt_r + 16'h0001;
          end
        end
        ICV_DONE:
        begin
          tick_cnt_r <= 16'h0000;
          state_r    <= ICV_IDLE;
        end
        default:
          state_r <= ICV_IDLE;
      endcase
    end
  end

  assign conv_done = (state_r == ICV_DONE);
  assign loss_done = conv_done && !inductance_only_drive;

  always_comb
  begin
    result.valid   = conv_done;
    result.is_loss = loss_done;
    result.value   = loss_done ? loss_sample_i : induct_sample_i;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      last_result_r  <= 16'h0000;
      last_is_loss_r <= 1'b0;
    end
    else if (result.valid)
    begin
      last_result_r  <= result.value;
      last_is_loss_r <= result.is_loss;
    end
  end

  always_comb
  begin
    events = 2'h0;
    events[`ICV_ST_LOSS_ABOVE] = loss_done && (loss_sample_i > loss_upper_limit_r);
    events[`ICV_ST_CONV_DONE]  = conv_done;
  end

  // A new event beats a same-cycle write-one clear
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      status_r <= 2'h0;
    else if (wr_en && addr == `ICV_OFS_STATUS)
      status_r <= (status_r & ~pwdata_i[1:0]) | events;
    else
      status_r <= status_r | events;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o  <= access && !pready_o;
      pslverr_o <= access && !pready_o && !mapped;
      prdata_o  <= 32'h0000_0000;
      if (psel_i && !pwrite_i && mapped)
      begin
        if (addr == `ICV_OFS_DIGITAL_SETUP)
          prdata_o <= {24'h00_0000, digital_setup_r};
        else if (addr == `ICV_OFS_ALT_SETUP)
          prdata_o <= {24'h00_0000, alternate_setup_r};
        else if (addr == `ICV_OFS_LIMIT_LOW)
          prdata_o <= {24'h00_0000, limit_low_stage_r};
        else if (addr == `ICV_OFS_LIMIT_HIGH)
          prdata_o <= {24'h00_0000, limit_high_r};
        else if (addr == `ICV_OFS_SHUTDOWN)
          prdata_o <= {30'h0000_0000, shutdown_req_r, 1'b0};
        else if (addr == `ICV_OFS_RESULT)
          prdata_o <= {15'h0000, last_is_loss_r, last_result_r};
        else if (addr == `ICV_OFS_STATUS)
          prdata_o <= {30'h0000_0000, status_r};
        else if (addr == `ICV_OFS_MASK)
          prdata_o <= {30'h0000_0000, mask_r};
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      irq_o              <= 1'b0;
      shutdown_o         <= 1'b0;
      loss_active_o      <= 1'b1;
      conv_busy_o        <= 1'b0;
      loss_upper_limit_o <= 16'h0000;
    end
    else
    begin
      irq_o              <= |(status_r & mask_r);
      shutdown_o         <= shutdown_req_r && alternate_setup_r[`ICV_BIT_SHUTDOWN_GATE];
      loss_active_o      <= !inductance_only_drive;
      conv_busy_o        <= (state_r == ICV_RUN);
      loss_upper_limit_o <= loss_upper_limit_r;
    end
  end
endmodule

// File: sim/icv_top_chk.sv
`timescale 1ns/100ps
module icv_top_chk
(
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        irq_o,
  input wire logic        shutdown_o,
  input wire logic        loss_active_o,
  input wire logic        conv_busy_o,
  input wire logic [15:0] loss_upper_limit_o
);
  logic       acc;
  logic       wr5;
  logic       wr6;
  logic       wr7;
  logic [7:0] lo_r;
  logic [7:0] hi_r;
  // First access cycle only, so a held request counts once
  assign acc = psel_i && penable_i && pwrite_i && !pready_o;
  assign wr5 = acc && paddr_i == 32'h14;
  assign wr6 = acc && paddr_i == 32'h18;
  assign wr7 = acc && paddr_i == 32'h1c;
  always_ff @(posedge sys_clk_i)
    if (rst_i)
      lo_r <= 8'h0;
    else if (wr6)
      lo_r <= pwdata_i[7:0];
  always_ff @(posedge sys_clk_i)
    if (rst_i)
      hi_r <= 8'h0;
    else if (wr7)
      hi_r <= pwdata_i[7:0];
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  wait_state_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("no ready after one wait state");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  err_data_a: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
    else $error("error response malformed");
  gate_off_a: assert property (wr5 && !pwdata_i[1] |-> ##[1:2] !shutdown_o)
    else $error("shutdown without gate");
  drive_only_a: assert property (wr5 && pwdata_i[0] |-> ##[1:2] !loss_active_o)
    else $error("loss still active");
  drive_both_a: assert property (wr5 && !pwdata_i[0] |-> ##[1:2] loss_active_o)
    else $error("loss not active");
  limit_hold_a: assert property ($changed(loss_upper_limit_o) |-> $past(wr7) || $past(wr7, 2))
    else $error("limit moved without high byte write");
  limit_join_a: assert property (wr7 |=> ##[0:1] loss_upper_limit_o == {hi_r, lo_r})
    else $error("limit not high times 256 plus low");
  cover property (wr7);
  cover property ($fell(conv_busy_o));
  cover property ($rose(irq_o));
endmodule
bind icv_top icv_top_chk i_icv_top_chk (.*);

// File: sim/icv_sensor_model.sv
`timescale 1ns/100ps
module icv_sensor_model
(
  input  wire logic [15:0] loss_i,
  output logic             tick_o,
  output logic [15:0]      loss_o,
  output logic [15:0]      induct_o
);
  // Free-running oscillator, phase unrelated to the system clock
  initial
  begin
    tick_o = 1'b0;
    forever #200 tick_o = ~tick_o;
  end
  assign loss_o = loss_i;
  assign induct_o = ~loss_i;
endmodule

// File: sim/inductive_conv_config_threshold_test.sv
`timescale 1ns/100ps
module inductive_conv_config_threshold_test;
  logic        sys_clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic        tick, irq_o, shutdown_o, loss_active_o, conv_busy_o;
  logic [31:0] paddr_i, pwdata_i, prdata_o, r;
  logic [15:0] loss_upper_limit_o, loss_v, loss_s, ind_s, lim;
  logic [32:0] e;
  logic [32:0] expq[$];
  int          n_fail, compares, seed, len;
  int          per[8] = '{384, 384, 192, 384, 768, 1536, 3072, 6144};
  icv_top i_icv_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sensor_tick_i(tick),
    .loss_sample_i(loss_s), .induct_sample_i(ind_s), .irq_o(irq_o), .shutdown_o(shutdown_o),
    .loss_active_o(loss_active_o), .conv_busy_o(conv_busy_o),
    .loss_upper_limit_o(loss_upper_limit_o));
  icv_sensor_model i_icv_sensor_model (.loss_i(loss_v), .tick_o(tick), .loss_o(loss_s),
    .induct_o(ind_s));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  task automatic give_verdict();
    $display("Compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge sys_clk_i);
      k++;
    end
    while (pready_o !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      n_fail++;
      give_verdict();
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic err);
    expq.push_back({err, d});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic hold(input logic lvl, inout int k);
    while (conv_busy_o === lvl && k < 20000)
    begin
      @(posedge sys_clk_i);
      k++;
    end
  endtask
  // Measures the first conversion that starts after the call
  task automatic conv();
    int k;
    int s;
    k = 0;
    hold(1'b1, k);
    hold(1'b0, k);
    s = k;
    hold(1'b1, k);
    len = k - s;
    if (k >= 20000)
    begin
      n_fail++;
      give_verdict();
    end
    repeat (3) @(posedge sys_clk_i);
  endtask
  always @(posedge sys_clk_i)
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i && expq.size() > 0)
    begin
      e = expq.pop_front();
      chk({pslverr_o, prdata_o}, e);
    end
  initial
  begin
    seed = 32'h7846;
    n_fail = 0;
    compares = 0;
    {rst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, loss_v} = {1'b1, 83'h0};
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    for (int a = 4; a < 8; a++) rd(a * 4, (a == 4) ? 3 : 0, 1'b0);
    rd(32'hc0, 0, 1'b1);
    rd(32'h1, 0, 1'b1);
    apb(1'b1, 32'h2c, 2);
    repeat (3) @(posedge sys_clk_i);
    chk(shutdown_o, 0);
    apb(1'b1, 32'h14, 2);
    rd(32'h14, 2, 1'b0);
    chk(shutdown_o, 1);
    apb(1'b1, 32'h2c, 0);
    apb(1'b1, 32'h14, 0);
    // Tick period is four system cycles; sync and phase give one tick of slack
    for (int c = 2; c < 8; c++)
    begin
      apb(1'b1, 32'h10, c);
      conv();
      chk(len >= 4 * per[c] / 3 - 4 && len <= 4 * per[c] / 3 + 4, 1);
    end
    apb(1'b1, 32'h10, 2);
    r = $random(seed);
    lim = {1'b0, r[14:0]};
    apb(1'b1, 32'h18, lim[7:0]);
    rd(32'h18, lim[7:0], 1'b0);
    chk(loss_upper_limit_o, 0);
    apb(1'b1, 32'h1c, lim[15:8]);
    chk(loss_upper_limit_o, lim);
    apb(1'b1, 32'ha0, 1);
    loss_v <= lim;
    conv();
    apb(1'b1, 32'h90, 3);
    conv();
    rd(32'h90, 2, 1'b0);
    chk(irq_o, 0);
    loss_v <= lim + 16'h1 + r[23:16];
    conv();
    rd(32'h90, 3, 1'b0);
    chk(irq_o, 1);
    apb(1'b1, 32'ha0, 0);
    chk(irq_o, 0);
    // Below the limit so a conversion ending here cannot set the flag again
    loss_v <= 16'h0;
    apb(1'b1, 32'h90, 1);
    rd(32'h90, 2, 1'b0);
    loss_v <= lim + 16'h1;
    apb(1'b1, 32'h10, 6);
    apb(1'b1, 32'h14, 1);
    chk(loss_active_o, 0);
    conv();
    apb(1'b1, 32'h90, 3);
    conv();
    rd(32'h90, 2, 1'b0);
    apb(1'b1, 32'h14, 0);
    chk(loss_active_o, 1);
    conv();
    rd(32'h90, 3, 1'b0);
    give_verdict();
  end
endmodule
